// File: rtl/sdem_monitor.v
// servo deviation error monitor with parameter staging and the
// first servo-on magnetic pole detection sequence.
// assumes all inputs synchronous to clock; rst models power cycling.
//
// How it works
// R1: position check enabled by select bit value 1
// R2: speed check enabled by select bit value 2
// R3: torque check enabled by select bit value 4
// R4: all selected checks run together
// R5: select digit resets to 3
// R6: position deviation over limit raises alarm, stops
// R7: position threshold defaults to 0.09 rev
// R8: speed deviation over limit raises control alarm
// R9: speed threshold defaults to 100 r/min
// R10: torque deviation over limit raises control alarm
// R11: torque threshold defaults to 100 percent
// R12: written parameters wait for power cycle
// R13: select also applies on controller reset
// R14: incremental system detects poles at first servo-on
// R15: controller waits for servo-on status before positioning
// R16: test-mode overload ends pole detection, servo off
// R17: controller sends no positioning before ready
// R18: absolute difference every cycle, alarms latch
`timescale 1ns/1ps
`default_nettype none
`include "sdem_regs.vh"

module sdem_monitor #(
  parameter COUNTS_PER_REV = 32'h64,    // position counts per revolution
  parameter POS_WIDTH      = 32
) (
  input  wire                 clock,
  input  wire                 rst,
  input  wire                 ce,
  input  wire                 storeInit,
  input  wire                 paramWrite,
  input  wire [1:0]           paramIndex,
  input  wire [15:0]          paramData,
  input  wire                 controllerReset,
  input  wire                 alarmReset,
  input  wire                 incrementalSys,
  input  wire                 testMode,
  input  wire                 servoOnCmd,
  input  wire                 poleDetectDone,
  input  wire                 overloadAlarmOne,
  input  wire                 overloadAlarmTwo,
  input  wire                 overloadWarningOne,
  input  wire                 overloadWarningTwo,
  input  wire [POS_WIDTH-1:0] modelPosition,
  input  wire [POS_WIDTH-1:0] feedbackPosition,
  input  wire [15:0]          modelSpeed,
  input  wire [15:0]          feedbackSpeed,
  input  wire [15:0]          commandTorque,
  input  wire [15:0]          feedbackTorque,
  output reg                  paramRejected_q,
  output reg  [15:0]          activeSelect_q,
  output reg                  positionDeviationAlarm_q,
  output reg                  servoControlErrorAlarm_q,
  output reg                  motorStop_q,
  output reg                  servoOnStatus_q,
  output reg                  ready_q,
  output reg                  poleDetectActive_q,
  output reg                  testEnd_q
);

  // servo sequence states; ST_POLE is entered at servo-on of an incremental system until one detection completes per power-up
  localparam [1:0] ST_OFF  = 2'b00;
  localparam [1:0] ST_POLE = 2'b01;
  localparam [1:0] ST_ON   = 2'b10;
  localparam       PW      = POS_WIDTH + 1;

  // staged copies: model the non-volatile store, so rst leaves them alone
  reg [15:0] stSelect_q;
  reg [15:0] stPos_q;
  reg [15:0] stSpd_q;
  reg [15:0] stTrq_q;
  // values in force
  reg [15:0] actPos_q;
  reg [15:0] actSpd_q;
  reg [15:0] actTrq_q;
  reg        loadPending_q;
  reg        poleDone_q;
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  // set by a test-mode overload stop, cleared when the command drops
  reg        testHold_q;

  // working values of the three comparisons and the sequence
  wire        anyOverload;
  wire        testStop;
  wire        anyAlarm;
  wire        checking;
  reg  [PW-1:0] posDiff;
  reg  [PW-1:0] posMag;
  reg  [16:0]   spdDiff;
  reg  [16:0]   spdMag;
  reg  [16:0]   trqDiff;
  reg  [16:0]   trqMag;
  reg  [47:0]   posThresh;
  reg  [15:0]   spdThresh;
  reg  [15:0]   trqThresh;
  reg           writeOk;
  wire          posTrip;
  wire          spdTrip;
  wire          trqTrip;

  // range check of a write; out-of-range values are not stored
  // zero is legal for position and speed, where it selects the built-in
  // default; torque has no such escape, its default is its reset value
  always @* begin
    case (paramIndex)
      `SDEM_IDX_SELECT:    writeOk = 1'b1;
      `SDEM_IDX_POS_LIMIT: writeOk = (paramData == 16'h0000) ||
                             ((paramData >= `SDEM_LIMIT_MIN) &&
                              (paramData <= `SDEM_POS_MAX));
      `SDEM_IDX_SPD_LIMIT: writeOk = (paramData == 16'h0000) ||
                             ((paramData >= `SDEM_LIMIT_MIN) &&
                              (paramData <= `SDEM_SPD_MAX));
      default:             writeOk = (paramData >= `SDEM_LIMIT_MIN) &&
                                     (paramData <= `SDEM_TRQ_MAX);
    endcase
  end

  // parameter store; written values only land here, not in force
  // storeInit is a factory reset of the non-volatile copy; rst must not
  // touch it, or every power cycle would throw the written values away
  always @(posedge clock or posedge storeInit) begin
    if (storeInit) begin
      stSelect_q <= `SDEM_SELECT_RESET; // R5
      stPos_q    <= `SDEM_POS_RESET;
      stSpd_q    <= `SDEM_SPD_RESET;
      stTrq_q    <= `SDEM_TRQ_RESET;    // R11
    end else if (ce && paramWrite && writeOk) begin
      if (paramIndex == `SDEM_IDX_SELECT) begin
        stSelect_q <= paramData;        // R12
      end else if (paramIndex == `SDEM_IDX_POS_LIMIT) begin
        stPos_q <= paramData;           // R12
      end else if (paramIndex == `SDEM_IDX_SPD_LIMIT) begin
        stSpd_q <= paramData;           // R12
      end else begin
        stTrq_q <= paramData;           // R12
      end
    end
  end

  // write rejection flag, one cycle per refused write
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      paramRejected_q <= 1'b0;
    end else if (ce) begin
      paramRejected_q <= paramWrite && !writeOk;
    end
  end

  // values in force: defaults at power-up, staged copy one cycle later
  // limits change only here, so a running check never sees half a set;
  // a controller reset reloads the select word alone
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      activeSelect_q <= `SDEM_SELECT_RESET; // R5
      actPos_q       <= `SDEM_POS_RESET;
      actSpd_q       <= `SDEM_SPD_RESET;
      actTrq_q       <= `SDEM_TRQ_RESET;    // R11
      loadPending_q  <= 1'b1;
    end else if (ce) begin
      if (loadPending_q) begin
        activeSelect_q <= stSelect_q;       // R12
        actPos_q       <= stPos_q;          // R12
        actSpd_q       <= stSpd_q;          // R12
        actTrq_q       <= stTrq_q;          // R12
        loadPending_q  <= 1'b0;
      end else if (controllerReset) begin
        activeSelect_q <= stSelect_q;       // R13
      end
    end
  end

  // thresholds; a zero limit means the built-in default
  // limits are whole revolutions; the default is nine hundredths, so a
  // COUNTS_PER_REV below 100 rounds the default position threshold down
  always @* begin
    if (actPos_q == 16'h0000) begin
      posThresh = (COUNTS_PER_REV * {32'h0, `SDEM_POS_DEF_CENTI}) /
                  48'h64;                   // R7
    end else begin
      posThresh = COUNTS_PER_REV * {32'h0, actPos_q};
    end
    spdThresh = (actSpd_q == 16'h0000) ? `SDEM_SPD_DEFAULT : actSpd_q; // R9
    trqThresh = actTrq_q;
  end

  // absolute differences, worked every cycle
  // one extra bit keeps a full-scale signed difference from wrapping
  always @* begin
    posDiff = {modelPosition[POS_WIDTH-1], modelPosition} -
              {feedbackPosition[POS_WIDTH-1], feedbackPosition};
    posMag  = posDiff[PW-1] ? (~posDiff + {{(PW-1){1'b0}}, 1'b1})
                            : posDiff;      // R18
    spdDiff = {modelSpeed[15], modelSpeed} -
              {feedbackSpeed[15], feedbackSpeed};
    spdMag  = spdDiff[16] ? (~spdDiff + 17'h00001) : spdDiff; // R18
    trqDiff = {commandTorque[15], commandTorque} -
              {feedbackTorque[15], feedbackTorque};
    trqMag  = trqDiff[16] ? (~trqDiff + 17'h00001) : trqDiff; // R18
  end

  // checks only while the drive is energised and parameters are settled
  // with the servo off the feedback drifts freely and would trip at once
  assign checking = (state_q != ST_OFF) && !loadPending_q;

  // each selected check trips on its own; several may run at once
  assign posTrip = checking && activeSelect_q[`SDEM_SEL_POS_BIT] && // R1
                   ({{(48-PW){1'b0}}, posMag} > posThresh);        // R6
  assign spdTrip = checking && activeSelect_q[`SDEM_SEL_SPD_BIT] && // R2
                   (spdMag > {1'b0, spdThresh});                   // R8
  assign trqTrip = checking && activeSelect_q[`SDEM_SEL_TRQ_BIT] && // R3
                   (trqMag > {1'b0, trqThresh});                   // R10

  // latched alarms; a trip in the clearing cycle still wins
  // motorStop_q mirrors the alarm flops, so the stop drops with the clear
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      positionDeviationAlarm_q <= 1'b0;
      servoControlErrorAlarm_q <= 1'b0;
      motorStop_q              <= 1'b0;
    end else if (ce) begin
      positionDeviationAlarm_q <= posTrip ||
        (positionDeviationAlarm_q && !alarmReset);     // R18
      servoControlErrorAlarm_q <= spdTrip || trqTrip ||
        (servoControlErrorAlarm_q && !alarmReset);     // R4
      motorStop_q <= posTrip || spdTrip || trqTrip ||
        ((positionDeviationAlarm_q || servoControlErrorAlarm_q) &&
         !alarmReset);                                 // R6
    end
  end

  // live trips count as well, so the drive drops in the tripping cycle
  assign anyAlarm    = positionDeviationAlarm_q || servoControlErrorAlarm_q ||
                       posTrip || spdTrip || trqTrip;
  assign anyOverload = overloadAlarmOne || overloadAlarmTwo ||
                       overloadWarningOne || overloadWarningTwo;

  // overload during test-mode detection ends the test and the drive
  assign testStop    = (state_q == ST_POLE) && testMode && anyOverload &&
                       !anyAlarm && servoOnCmd;   // R16

  // servo sequence: pole detection once per power-up on an incremental system, then servo-on
  // after a test-mode overload stop the drive stays off until the command
  // drops; otherwise detection would start again on the next cycle
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (servoOnCmd && !anyAlarm && !loadPending_q &&
            !testHold_q) begin              // R16
          if (incrementalSys && !poleDone_q) begin
            state_d = ST_POLE;              // R14
          end else begin
            state_d = ST_ON;
          end
        end
      end
      ST_POLE: begin
        if (anyAlarm || !servoOnCmd) begin
          state_d = ST_OFF;
        end else if (testMode && anyOverload) begin
          state_d = ST_OFF;                 // R16
        end else if (poleDetectDone) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (anyAlarm || !servoOnCmd) begin
          state_d = ST_OFF;                 // R6
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  // state and status flops; status drives the controller's interlock
  // poleDone_q survives servo-off and alarms; only rst clears it
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q            <= ST_OFF;
      poleDone_q         <= 1'b0;
      testHold_q         <= 1'b0;
      servoOnStatus_q    <= 1'b0;
      ready_q            <= 1'b0;
      poleDetectActive_q <= 1'b0;
      testEnd_q          <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      if (state_q == ST_POLE && state_d == ST_ON) begin
        poleDone_q <= 1'b1;                 // R14
      end
      servoOnStatus_q    <= (state_d == ST_ON);   // R15
      ready_q            <= (state_d == ST_ON);   // R17
      poleDetectActive_q <= (state_d == ST_POLE);
      testEnd_q          <= testStop;             // R16
      if (testStop) begin
        testHold_q <= 1'b1;                 // R16
      end else if (!servoOnCmd) begin
        testHold_q <= 1'b0;
      end
    end
  end

endmodule // sdem_monitor

`default_nettype wire

// File: rtl/sdem_regs.vh
// constants of the servo deviation error monitor: parameter indexes,
// field positions, reset values, defaults and setting ranges.
// assumes plain Verilog-2005; included by bare name.
`ifndef SDEM_REGS_VH
`define SDEM_REGS_VH

// parameter index on the write port
`define SDEM_IDX_SELECT     2'h0
`define SDEM_IDX_POS_LIMIT  2'h1
`define SDEM_IDX_SPD_LIMIT  2'h2
`define SDEM_IDX_TRQ_LIMIT  2'h3

// bits of the lowest digit of deviation_check_select
`define SDEM_SEL_POS_BIT    0
`define SDEM_SEL_SPD_BIT    1
`define SDEM_SEL_TRQ_BIT    2

// reset values of the four parameters
`define SDEM_SELECT_RESET   16'h0003
`define SDEM_POS_RESET      16'h0000
`define SDEM_SPD_RESET      16'h0000
`define SDEM_TRQ_RESET      16'h0064

// thresholds used while a limit still holds zero
`define SDEM_POS_DEF_CENTI  16'h0009
`define SDEM_SPD_DEFAULT    16'h0064

// legal setting ranges
`define SDEM_LIMIT_MIN      16'h0001
`define SDEM_POS_MAX        16'h03E8
`define SDEM_SPD_MAX        16'h07D0
`define SDEM_TRQ_MAX        16'h03E8

`endif

// File: verification/sdem_ctrl_model.sv
// motion controller model: parameter writes, controller reset, servo-on
// assumes the monitor samples its inputs on the rising clock edge
`timescale 1ns/1ps
`default_nettype none

module sdem_ctrl_model (
  input  wire logic        clock,
  input  wire logic        ready_q,
  output var  logic        paramWrite,
  output var  logic [1:0]  paramIndex,
  output var  logic [15:0] paramData,
  output var  logic        controllerReset,
  output var  logic        servoOnCmd
);
  initial {paramWrite, controllerReset, servoOnCmd, paramIndex,
           paramData} = 21'h0;

  // one write; bus inverted after so stale data never looks valid
  task automatic wr(input logic [1:0] i, input logic [15:0] d);
    @(posedge clock);
    paramWrite <= 1'b1;
    paramIndex <= i;
    paramData <= d;
    @(posedge clock);
    paramWrite <= 1'b0;
    paramIndex <= ~i;
    paramData <= ~d;
  endtask

  task automatic apply();
    @(posedge clock) controllerReset <= 1'b1;
    @(posedge clock) controllerReset <= 1'b0;
  endtask

  task automatic servo(input logic on);
    @(posedge clock) servoOnCmd <= on;
  endtask

  // positioning only after ready; bounded so a dead servo cannot hang us
  task automatic waitReady(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge clock);
      ok = (ready_q === 1'b1);
    end
  endtask
endmodule // sdem_ctrl_model

`default_nettype wire

// File: verification/sdem_props.sv
// checker for the servo deviation error monitor outputs
// assumes it is bound to sdem_monitor, one clock domain
`timescale 1ns/1ps
`default_nettype none

module sdem_props (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        paramWrite,
  input wire logic [1:0]  paramIndex,
  input wire logic [15:0] paramData,
  input wire logic        alarmReset,
  input wire logic        testMode,
  input wire logic        servoOnCmd,
  input wire logic        poleDetectDone,
  input wire logic        overloadWarningTwo,
  input wire logic        paramRejected_q,
  input wire logic [15:0] activeSelect_q,
  input wire logic        positionDeviationAlarm_q,
  input wire logic        servoControlErrorAlarm_q,
  input wire logic        motorStop_q,
  input wire logic        servoOnStatus_q,
  input wire logic        ready_q,
  input wire logic        poleDetectActive_q,
  input wire logic        testEnd_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // sampled value is the reset image, before the store copy lands
  sel_reset_a: assert property ($fell(rst) |->
    activeSelect_q == 16'h0003) else $error("select not 3 after reset");
  pos_gate_a: assert property (ce && !activeSelect_q[0] &&
    !positionDeviationAlarm_q |=> !positionDeviationAlarm_q)
    else $error("position alarm while check off");
  stop_follow_a: assert property (positionDeviationAlarm_q ||
    servoControlErrorAlarm_q |-> motorStop_q && !servoOnStatus_q)
    else $error("alarm without motor stop");
  ready_match_a: assert property (ready_q == servoOnStatus_q)
    else $error("ready differs from servo-on status");
  alarm_hold_a: assert property (ce && !alarmReset &&
    servoControlErrorAlarm_q |=> servoControlErrorAlarm_q)
    else $error("control alarm dropped without reset");
  pole_finish_a: assert property (ce && poleDetectActive_q &&
    poleDetectDone && servoOnCmd && !motorStop_q && !testMode
    |=> servoOnStatus_q && !poleDetectActive_q)
    else $error("pole detection did not hand over");
  test_end_a: assert property (ce && poleDetectActive_q && testMode &&
    overloadWarningTwo |=> testEnd_q && !servoOnStatus_q ##1 !testEnd_q)
    else $error("test overload did not end detection");
  limit_reject_a: assert property (ce && paramWrite &&
    paramIndex == 2'h3 && (paramData == 16'h0000 || paramData > 16'h03E8)
    |=> paramRejected_q) else $error("bad torque limit taken");

  cover property (servoControlErrorAlarm_q);
  cover property (positionDeviationAlarm_q);
  cover property (testEnd_q);
endmodule // sdem_props

`default_nettype wire

// File: verification/sdem_tb.sv
// self-checking bench for the servo deviation error monitor
// assumes the controller model drives writes and servo-on commands
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clock, rst, ce, storeInit, alarmReset, testMode, poleDetectDone;
  logic incrementalSys, overloadAlarmOne, overloadAlarmTwo, ok;
  logic overloadWarningOne, overloadWarningTwo;
  logic [31:0] modelPosition, feedbackPosition;
  logic [15:0] modelSpeed, feedbackSpeed, commandTorque, feedbackTorque;
  wire paramWrite, controllerReset, servoOnCmd, paramRejected_q;
  wire positionDeviationAlarm_q, servoControlErrorAlarm_q, motorStop_q;
  wire servoOnStatus_q, ready_q, poleDetectActive_q, testEnd_q;
  wire [1:0] paramIndex;
  wire [15:0] paramData, activeSelect_q;
  int fail_count, check_count;

  sdem_monitor u_sdem_monitor (.*);
  sdem_ctrl_model u_sdem_ctrl_model (.*);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  // offsets of feedback from model, settled two edges later
  task automatic dev(input logic [31:0] p, input logic [15:0] s, t);
    @(posedge clock);
    feedbackPosition <= modelPosition + p;
    feedbackSpeed <= modelSpeed + s;
    feedbackTorque <= commandTorque + t;
    tick(2);
  endtask

  // clear alarms, then servo cycle; no second pole detection expected
  task automatic clr();
    dev(32'h0, 16'h0, 16'h0);
    @(posedge clock) alarmReset <= 1'b1;
    @(posedge clock) alarmReset <= 1'b0;
    u_sdem_ctrl_model.servo(1'b0);
    u_sdem_ctrl_model.servo(1'b1);
    u_sdem_ctrl_model.waitReady(ok);
    chk("servo rearm", ok, 1);
  endtask

  task automatic t_pole();
    u_sdem_ctrl_model.servo(1'b1);
    tick(1);
    chk("poleDetectActive_q", poleDetectActive_q, 1);
    chk("servoOnStatus_q", servoOnStatus_q, 0);
    @(posedge clock) poleDetectDone <= 1'b1;
    @(posedge clock) poleDetectDone <= 1'b0;
    u_sdem_ctrl_model.waitReady(ok);
    chk("ready after pole", ok, 1);
    $display("pole detection test done");
  endtask

  task automatic t_speed();
    dev(32'h0, 16'h0064, 16'h0); // 100 is not over the default
    chk("speed alarm at 100", servoControlErrorAlarm_q, 0);
    dev(32'h0, 16'h0065, 16'h0);
    chk("speed alarm at 101", servoControlErrorAlarm_q, 1);
    chk("motorStop_q", motorStop_q, 1);
    clr();
    $display("speed deviation test done");
  endtask

  task automatic t_pos();
    dev(32'h9, 16'h0, 16'h0); // 0.09 rev is 9 counts
    chk("position alarm at 9", positionDeviationAlarm_q, 0);
    dev(32'hA, 16'h0, 16'h0);
    chk("position alarm at 10", positionDeviationAlarm_q, 1);
    clr();
    $display("position deviation test done");
  endtask

  task automatic t_trq();
    dev(32'h0, 16'h0, 16'h01F4);
    chk("torque off by default", servoControlErrorAlarm_q, 0);
    dev(32'h0, 16'h0, 16'h0); // settle before torque checking turns on
    u_sdem_ctrl_model.wr(2'h0, 16'h0004);
    u_sdem_ctrl_model.apply();
    tick(0);
    chk("activeSelect_q", activeSelect_q, 16'h0004);
    dev(32'h32, 16'h0, 16'h0064);
    chk("position unchecked", positionDeviationAlarm_q, 0);
    chk("torque at 100", servoControlErrorAlarm_q, 0);
    dev(32'h32, 16'h0, 16'h0065);
    chk("torque at 101", servoControlErrorAlarm_q, 1);
    clr();
    $display("torque deviation test done");
  endtask

  task automatic t_power();
    u_sdem_ctrl_model.wr(2'h3, 16'h0000);
    tick(0);
    chk("paramRejected_q", paramRejected_q, 1);
    u_sdem_ctrl_model.wr(2'h2, 16'h07D1);
    tick(0);
    chk("speed limit 2001", paramRejected_q, 1);
    u_sdem_ctrl_model.wr(2'h1, 16'h03E8);
    tick(0);
    chk("position limit 1000", paramRejected_q, 0);
    u_sdem_ctrl_model.wr(2'h0, 16'h0002);
    u_sdem_ctrl_model.servo(1'b0);
    tick(1);
    chk("select before power cycle", activeSelect_q, 16'h0004);
    @(posedge clock) rst <= 1'b1;
    @(posedge clock) rst <= 1'b0;
    tick(2);
    chk("select after power cycle", activeSelect_q, 16'h0002);
    @(posedge clock) testMode <= 1'b1;
    u_sdem_ctrl_model.servo(1'b1);
    tick(1);
    chk("pole again", poleDetectActive_q, 1);
    @(posedge clock) overloadWarningTwo <= 1'b1;
    tick(1);
    chk("testEnd_q", testEnd_q, 1);
    chk("servo off", servoOnStatus_q | poleDetectActive_q, 0);
    tick(2);
    chk("held off", testEnd_q | poleDetectActive_q, 0);
    $display("parameter and test mode test done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog well past the fewer than a hundred cycles the tests need
  initial begin
    #(3000 * 100);
    fail_count++;
    results();
  end

  initial begin
    {rst, storeInit, ce, incrementalSys} = 4'hF;
    {alarmReset, testMode, poleDetectDone} = 3'h0;
    {overloadAlarmOne, overloadAlarmTwo} = 2'h0;
    {overloadWarningOne, overloadWarningTwo} = 2'h0;
    {modelPosition, feedbackPosition} = {2{32'h00001000}};
    {modelSpeed, feedbackSpeed} = {2{16'h0040}};
    {commandTorque, feedbackTorque} = {2{16'h0040}};
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    storeInit <= 1'b0;
    tick(2);
    chk("activeSelect_q", activeSelect_q, 16'h0003);
    t_pole();
    t_speed();
    t_pos();
    t_trq();
    t_power();
    results();
  end
endmodule // testbench

bind sdem_monitor sdem_props u_sdem_props (
  .clock(clock), .rst(rst), .ce(ce), .paramWrite(paramWrite),
  .paramIndex(paramIndex), .paramData(paramData), .alarmReset(alarmReset),
  .testMode(testMode), .servoOnCmd(servoOnCmd),
  .poleDetectDone(poleDetectDone), .overloadWarningTwo(overloadWarningTwo),
  .paramRejected_q(paramRejected_q), .activeSelect_q(activeSelect_q),
  .positionDeviationAlarm_q(positionDeviationAlarm_q),
  .servoControlErrorAlarm_q(servoControlErrorAlarm_q),
  .motorStop_q(motorStop_q), .servoOnStatus_q(servoOnStatus_q),
  .ready_q(ready_q), .poleDetectActive_q(poleDetectActive_q),
  .testEnd_q(testEnd_q)
);

`default_nettype wire
